//--- arxdr_fifo.sv
// Purpose: small character buffer between data recovery and the reader
// Assumes: reader may stall; writer waits on in_ready
// Notes: read data comes from a register, so capacity is DEPTH plus one
`timescale 1ns/100ps
module arxdr_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = arxdr_pkg::FIFO_DEPTH
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;

  // honest full: writer is held off while the array is full
  assign o_in_ready = (count != FULL);
  wire do_wr = i_in_valid && o_in_ready;
  wire do_rd = (count != '0) && (!o_out_valid || i_out_ready);

  // array write, no reset needed on storage
  always_ff @(posedge i_sys_clk)
  begin
    if (do_wr)
      mem[wr_ptr] <= i_in_data;
  end

  // pointers, level and registered output stage
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      o_out_valid <= 1'b0;
      o_out_data <= '0;
    end
    else
    begin
      wr_ptr <= do_wr ? wr_ptr + 1'b1 : wr_ptr;
      rd_ptr <= do_rd ? rd_ptr + 1'b1 : rd_ptr;
      count <= count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
      if (do_rd)
      begin
        o_out_data <= mem[rd_ptr];
        o_out_valid <= 1'b1;
      end
      else if (i_out_ready)
        o_out_valid <= 1'b0;
    end
  end

endmodule

//--- arxdr_pkg.sv
// Purpose: shared constants and types for the serial receive data recovery block
// Assumes: 40 MHz module clock, sixteen oversample ticks per bit
// Notes: tick positions are numbered 1..16 within each bit period
package arxdr_pkg;

  // module clock and default line rate
  localparam int CLK_HZ = 40_000_000;
  localparam int BAUD_DEFAULT = 9600;
  localparam int OSR = 16;
  // cycles per oversample tick, rounded down so the tick never runs slow
  localparam int TICK_DIV = CLK_HZ / (BAUD_DEFAULT * OSR);

  // oversample tick positions within one bit
  localparam logic [4:0] RT_FIRST = 5'h01;
  localparam logic [4:0] RT_VER_A = 5'h03;
  localparam logic [4:0] RT_VER_B = 5'h05;
  localparam logic [4:0] RT_VER_C = 5'h07;
  localparam logic [4:0] RT_MID_A = 5'h08;
  localparam logic [4:0] RT_MID_B = 5'h09;
  localparam logic [4:0] RT_MID_C = 5'h0A;
  localparam logic [4:0] RT_LAST = 5'h10;

  // ticks from start edge to end of stop sampling
  localparam int BITS_TO_STOP8 = 9;
  localparam int BITS_TO_STOP9 = 10;
  localparam int CHAR8_TICKS = BITS_TO_STOP8 * OSR + 10;
  localparam int CHAR9_TICKS = BITS_TO_STOP9 * OSR + 10;

  // character buffer shape
  localparam int DATA_W = 9;
  localparam int FIFO_DEPTH = 16;

  // line history starts cleared, so three idle ticks come before any start
  localparam logic [2:0] HIST_RESET = 3'h0;

  typedef enum logic [2:0] {
    ARXDR_HUNT,
    ARXDR_START,
    ARXDR_DATA,
    ARXDR_STOP,
    ARXDR_PUSH
  } arxdr_state_t;

  // one recovered character with its status
  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic noise_flag;
    logic framing_error_flag;
    logic break_seen;
  } arxdr_char_t;

endpackage

//--- arxdr_rx.sv
// Purpose: data recovery front end of an asynchronous serial receiver
// Assumes: idle-high line, 8 or 9 data bits, one stop bit, no parity
// Notes: completed characters queue in a buffer; line is ignored while a character waits on a full buffer
// Function
// - reject start if two of RT3/5/7 high
// - failed start resets tick count, hunts again
// - single high verify sample flags noise
// - data bit is majority of RT8/9/10
// - non-unanimous data samples flag noise
// - high start mid samples flag noise only
// - stop majority zero framing error, disagreement noise
// - missing stop one sets framing error
// - break character sets framing error
// - framing error appears with receive full
// - resync tick count on valid falling edges
// - 8-bit stop sampling ends at 154 ticks
// - 9-bit stop sampling ends at 170 ticks
// - sample pin on sixteen-per-bit ticks
// - start edge is zero after three ones
// - resync after start and 1-to-0 data
`timescale 1ns/100ps
module arxdr_rx #(
  parameter int TICK_DIV = arxdr_pkg::TICK_DIV,
  parameter int DEPTH = arxdr_pkg::FIFO_DEPTH
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic i_serial_input_pin,
  input wire logic i_rx_enable,
  input wire logic i_nine_bit,
  input wire logic i_rd_ready,
  output logic o_receive_full_flag,
  output arxdr_pkg::arxdr_char_t o_rx_char,
  output logic o_char_strobe,
  output logic o_busy
);

  localparam int CW = $bits(arxdr_pkg::arxdr_char_t);

  // three-sample helpers used for verify, data and stop decisions
  function automatic logic [1:0] f_ones(input logic [2:0] s);
    f_ones = 2'(s[0]) + 2'(s[1]) + 2'(s[2]);
  endfunction

  function automatic logic f_major(input logic [2:0] s);
    f_major = (f_ones(s) >= 2'h2);
  endfunction

  logic tick;
  logic rx_meta;
  logic rx_sync;
  logic [2:0] hist;
  arxdr_pkg::arxdr_state_t st;
  arxdr_pkg::arxdr_state_t next_st;
  logic [4:0] rt;
  logic [4:0] next_rt;
  logic [3:0] idx;
  logic [3:0] next_idx;
  logic last_bit;
  logic [1:0] early;
  logic [1:0] mid;
  logic [8:0] shreg;
  logic noise_acc;
  logic fe_acc;
  logic fifo_ready;
  arxdr_pkg::arxdr_char_t push_char;

  // oversample tick enable at sixteen per bit
  arxdr_tick_div #(
    .DIV(TICK_DIV)
  ) u_tick (
    .i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b),
    .i_enable(i_rx_enable),
    .o_tick(tick)
  );

  // pin resynchroniser; only the second stage feeds logic
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
    end
    else
    begin
      rx_meta <= i_serial_input_pin;
      rx_sync <= rx_meta;
    end
  end

  // tick position of the sample being taken now
  wire [4:0] cur_rt = (rt == arxdr_pkg::RT_LAST) ? arxdr_pkg::RT_FIRST : rt + 5'h01;
  wire [2:0] three = {early, rx_sync};
  wire [2:0] mids = {mid, rx_sync};
  wire [1:0] ver_ones = f_ones(three);
  wire at_ver_c = tick && (cur_rt == arxdr_pkg::RT_VER_C);
  wire at_mid_c = tick && (cur_rt == arxdr_pkg::RT_MID_C);
  wire in_mid = (cur_rt >= arxdr_pkg::RT_MID_A) && (cur_rt <= arxdr_pkg::RT_MID_C);

  // start edge needs three highs before the low sample
  wire start_edge = tick && (st == arxdr_pkg::ARXDR_HUNT) && (hist == 3'h7) && !rx_sync;
  wire start_fail = at_ver_c && (st == arxdr_pkg::ARXDR_START) && (ver_ones >= 2'h2);
  wire start_noisy = at_ver_c && (st == arxdr_pkg::ARXDR_START) && (ver_ones == 2'h1);
  wire start_mid = at_mid_c && (st == arxdr_pkg::ARXDR_START);
  wire data_eval = at_mid_c && (st == arxdr_pkg::ARXDR_DATA);
  wire stop_eval = at_mid_c && (st == arxdr_pkg::ARXDR_STOP);
  wire mid_bit = f_major(mids);
  wire mid_noisy = (mids != 3'h0) && (mids != 3'h7);

  // falling edge inside the character after a bit judged one; the mid
  // samples are left alone so a glitch there cannot move the window
  wire fall = tick && hist[0] && !rx_sync;
  wire resync = fall && (st == arxdr_pkg::ARXDR_DATA) && last_bit && !in_mid;
  wire early_jump = resync && (cur_rt > arxdr_pkg::RT_MID_C);
  wire [3:0] last_idx = i_nine_bit ? 4'h8 : 4'h7;
  wire bit_end = tick && (cur_rt == arxdr_pkg::RT_LAST);

  // next state of the recovery sequence
  always_comb
  begin
    next_st = st;
    next_idx = idx;
    unique case (st)
      arxdr_pkg::ARXDR_HUNT:
      begin
        next_idx = 4'h0;
        if (start_edge)
          next_st = arxdr_pkg::ARXDR_START;
      end
      arxdr_pkg::ARXDR_START:
      begin
        if (start_fail)
          next_st = arxdr_pkg::ARXDR_HUNT;
        else if (bit_end)
          next_st = arxdr_pkg::ARXDR_DATA;
      end
      arxdr_pkg::ARXDR_DATA:
      begin
        if (bit_end || early_jump)
        begin
          if (idx == last_idx)
            next_st = arxdr_pkg::ARXDR_STOP;
          else
            next_idx = idx + 4'h1;
        end
      end
      arxdr_pkg::ARXDR_STOP:
      begin
        if (stop_eval)
          next_st = arxdr_pkg::ARXDR_PUSH;
      end
      arxdr_pkg::ARXDR_PUSH:
      begin
        if (fifo_ready)
          next_st = arxdr_pkg::ARXDR_HUNT;
      end
    endcase
    if (!i_rx_enable)
      next_st = arxdr_pkg::ARXDR_HUNT;
  end

  // tick counter: held at zero while hunting, restarted on edges
  always_comb
  begin
    next_rt = rt;
    if (next_st == arxdr_pkg::ARXDR_HUNT || next_st == arxdr_pkg::ARXDR_PUSH)
      next_rt = 5'h00;
    else if (start_edge || resync)
      next_rt = arxdr_pkg::RT_FIRST;
    else if (tick)
      next_rt = cur_rt;
  end

  // sequence registers
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      st <= arxdr_pkg::ARXDR_HUNT;
      rt <= 5'h00;
      idx <= 4'h0;
    end
    else
    begin
      st <= next_st;
      rt <= next_rt;
      idx <= next_idx;
    end
  end

  // line history, verify samples and mid samples, all on ticks
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      hist <= arxdr_pkg::HIST_RESET;
      early <= 2'h0;
      mid <= 2'h0;
    end
    else if (tick)
    begin
      hist <= {hist[1:0], rx_sync};
      if (cur_rt == arxdr_pkg::RT_VER_A || cur_rt == arxdr_pkg::RT_VER_B)
        early <= {early[0], rx_sync};
      if (cur_rt == arxdr_pkg::RT_MID_A || cur_rt == arxdr_pkg::RT_MID_B)
        mid <= {mid[0], rx_sync};
    end
  end

  // bit decisions and status gathered over the character
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      last_bit <= 1'b0;
      shreg <= 9'h000;
      noise_acc <= 1'b0;
      fe_acc <= 1'b0;
    end
    else if (start_edge)
    begin
      last_bit <= 1'b0;
      shreg <= 9'h000;
      noise_acc <= 1'b0;
      fe_acc <= 1'b0;
    end
    else
    begin
      if (data_eval)
      begin
        last_bit <= mid_bit;
        shreg[idx] <= mid_bit;
      end
      // noise from any part of the character sticks until the next start edge
      if (start_noisy || (start_mid && mids != 3'h0) || ((data_eval || stop_eval) && mid_noisy))
        noise_acc <= 1'b1;
      if (stop_eval && !mid_bit)
        fe_acc <= 1'b1;
    end
  end

  // an 8-bit character repeats bit 7 in the ninth position
  // one driver for the whole word keeps strict tools happy
  wire [8:0] push_data = i_nine_bit ? shreg : {shreg[7], shreg[7:0]};
  wire push_break = fe_acc && (shreg == 9'h000);
  assign push_char = '{data: push_data,
                       noise_flag: noise_acc,
                       framing_error_flag: fe_acc,
                       break_seen: push_break};

  // buffer; while it is full the block waits in push and ignores the line
  arxdr_fifo #(
    .WIDTH(CW),
    .DEPTH(DEPTH)
  ) u_fifo (
    .i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b),
    .i_in_valid(st == arxdr_pkg::ARXDR_PUSH),
    .i_in_data(push_char),
    .o_in_ready(fifo_ready),
    .o_out_valid(o_receive_full_flag),
    .o_out_data(o_rx_char),
    .i_out_ready(i_rd_ready)
  );

  // registered status outputs
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_char_strobe <= 1'b0;
      o_busy <= 1'b0;
    end
    else
    begin
      o_char_strobe <= (st == arxdr_pkg::ARXDR_PUSH) && fifo_ready;
      o_busy <= (next_st != arxdr_pkg::ARXDR_HUNT);
    end
  end

  // helper: ticks since the start edge, and whether any resync happened
  logic [7:0] char_ticks;
  logic resynced;
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      char_ticks <= 8'h00;
      resynced <= 1'b0;
    end
    else if (start_edge)
    begin
      char_ticks <= 8'h01;
      resynced <= 1'b0;
    end
    else if (tick)
    begin
      char_ticks <= char_ticks + 8'h01;
      resynced <= resynced || resync;
    end
  end

  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_b);

  a_start_reject: assert property (start_fail |=> st == arxdr_pkg::ARXDR_HUNT)
    else $error("start not rejected with two high verify samples");
  a_reject_restart: assert property (start_fail |=> rt == 5'h00 && !o_char_strobe)
    else $error("tick count not cleared after failed start");
  a_start_noise: assert property (start_noisy && !start_fail |=> noise_acc)
    else $error("single high verify sample did not flag noise");
  a_data_major: assert property (data_eval && i_rx_enable |=> last_bit == $past(f_major(mids)))
    else $error("data bit is not the majority of mid samples");
  a_data_noise: assert property (data_eval && mid_noisy |=> noise_acc ##1 noise_acc)
    else $error("mixed data samples did not flag noise");
  a_start_mid: assert property (start_mid && mids != 3'h0 && i_rx_enable
    |=> noise_acc && st == arxdr_pkg::ARXDR_START)
    else $error("start mid samples mishandled");
  a_stop_frame: assert property (stop_eval && !mid_bit |=> fe_acc && st == arxdr_pkg::ARXDR_PUSH)
    else $error("missing stop bit did not set framing error");
  a_fe_with_full: assert property (st == arxdr_pkg::ARXDR_PUSH && fifo_ready && fe_acc
    && !o_receive_full_flag |=> ##1 o_receive_full_flag && o_rx_char.framing_error_flag)
    else $error("framing error not shown with receive full");
  a_resync_edge: assert property (resync && i_rx_enable |=> rt == arxdr_pkg::RT_FIRST)
    else $error("tick count not resynchronised on falling edge");
  a_stop_time8: assert property (stop_eval && !i_nine_bit && !resynced |-> char_ticks == 8'd153)
    else $error("8-bit stop sampling not at 154 ticks");
  a_stop_time9: assert property (stop_eval && i_nine_bit && !resynced |-> char_ticks == 8'd169)
    else $error("9-bit stop sampling not at 170 ticks");

  a_start_begin: assert property (start_edge && i_rx_enable |=> rt == arxdr_pkg::RT_FIRST)
    else $error("start edge did not begin the tick count");
  a_strobe_pulse: assert property (o_char_strobe |=> !o_char_strobe)
    else $error("character strobe held longer than one cycle");
  a_tick_single: assert property (tick |=> !tick)
    else $error("oversample tick held longer than one cycle");

  c_char_done: cover property (o_char_strobe);
  c_start_noise: cover property (start_noisy && !start_fail);
  c_start_fail: cover property (start_fail);
  c_framing: cover property (stop_eval && !mid_bit);
  c_resync: cover property (resync);

endmodule

//--- arxdr_tick_div.sv
// Purpose: divides the module clock down to the oversample tick enable
// Assumes: single clock domain, DIV of at least 2
// Notes: tick is a one-cycle pulse; divider holds in reset while disabled
`timescale 1ns/100ps
module arxdr_tick_div #(
  parameter int DIV = arxdr_pkg::TICK_DIV
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic i_enable,
  output logic o_tick
);

  localparam int CW = $clog2(DIV);
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] cnt;
  wire at_last = (cnt == LAST);

  // free counter; restarts so the first tick after enable is a full period
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      cnt <= '0;
      o_tick <= 1'b0;
    end
    else
    begin
      cnt <= (!i_enable || at_last) ? '0 : cnt + 1'b1;
      o_tick <= i_enable && at_last;
    end
  end

endmodule

//--- arxdr_tx_model.sv
// Purpose: remote serial transmitter that drives the receive line slot by slot
// Assumes: one slot lasts one oversample tick of the receiver, TICK_DIV clocks
// Notes: line idles at mark level; the caller lays out every slot, noise included
`timescale 1ns/100ps
module arxdr_tx_model #(
  parameter int TICK_DIV = 4
) (
  input wire logic i_sys_clk,
  output logic o_line
);
  // idle mark level until the first frame
  initial o_line = 1'b1;

  // slots change just after an edge so each one meets exactly one tick
  task automatic send(input logic [255:0] f, input int n);
    for (int i = 0; i < n; i++)
    begin
      @(posedge i_sys_clk);
      o_line <= f[i];
      repeat (TICK_DIV - 1) @(posedge i_sys_clk);
    end
  endtask
endmodule

//--- testbench.sv
// Purpose: self-checking bench for the serial data recovery block
// Assumes: tick divider shortened to 4 clocks; partner model drives the line
// Notes: each scenario builds frames slot by slot and judges what comes back
`timescale 1ns/100ps
module testbench;
  localparam int TD = 4;
  logic i_sys_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic nine_bit = 1'b0;
  logic rd_ready = 1'b0;
  logic rx_line;
  logic full;
  logic strobe;
  logic busy;
  arxdr_pkg::arxdr_char_t rx_char;
  int fail_count = 0;
  int n_compared = 0;
  int cyc = 0;
  int ts;
  int nsl;
  int dk;
  int blen;
  logic [255:0] fr;
  logic [2:0] vp;
  logic [2:0] sm;
  logic [2:0] dm;
  logic [2:0] pm;
  logic sb;

  // 40 MHz clock and an edge counter for latency checks
  always #12.5 i_sys_clk = ~i_sys_clk;
  always @(posedge i_sys_clk) cyc <= cyc + 1;

  arxdr_rx #(.TICK_DIV(TD), .DEPTH(16)) i_dut (
    .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_serial_input_pin(rx_line),
    .i_rx_enable(1'b1), .i_nine_bit(nine_bit), .i_rd_ready(rd_ready),
    .o_receive_full_flag(full), .o_rx_char(rx_char), .o_char_strobe(strobe),
    .o_busy(busy));

  arxdr_tx_model #(.TICK_DIV(TD)) i_tx (.i_sys_clk(i_sys_clk), .o_line(rx_line));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // clean frame defaults: quiet start, clean stop, 16 slots a bit
  task automatic dflt;
    vp = 3'h0;
    sm = 3'h0;
    dm = 3'h0;
    pm = 3'h7;
    sb = 1'b1;
    dk = -1;
    blen = 16;
  endtask

  // slot image of one frame plus 16 idle slots; mid triplets are RT8,RT9,RT10
  task automatic build(input logic [8:0] d);
    int p;
    int nl;
    logic v;
    logic [2:0] m;
    p = 0;
    nl = nine_bit ? 10 : 9;
    fr = '1;
    for (int b = 0; b <= nl; b++)
    begin
      v = (b == 0) ? 1'b0 : (b == nl) ? sb : d[b-1];
      m = (b == 0) ? sm : (b == nl) ? pm : (b == dk + 1) ? dm : {3{v}};
      for (int s = 0; s < blen; s++)
      begin
        fr[p] = v;
        if (b == 0 && s inside {2, 4, 6}) fr[p] = vp[(6 - s) / 2];
        if (s inside {7, 8, 9}) fr[p] = m[9 - s];
        p++;
      end
    end
    nsl = p + 16;
  endtask

  function automatic logic [11:0] ch(input logic [8:0] d, input logic [2:0] f);
    ch = {nine_bit ? d : {d[7], d[7:0]}, f};
  endfunction

  // wait for a buffered character, judge it, then hand one read edge
  task automatic take(input logic [11:0] e);
    int k;
    k = 0;
    while (full !== 1'b1 && k < 2000)
    begin
      @(negedge i_sys_clk);
      k++;
    end
    check(full, 1);
    check(rx_char, e);
    @(posedge i_sys_clk);
    rd_ready <= 1'b1;
    @(posedge i_sys_clk);
    rd_ready <= 1'b0;
    @(negedge i_sys_clk);
  endtask

  // send one frame, note strobe latency from the first start slot edge
  task automatic xfer(input logic [8:0] d, input logic [11:0] e);
    int t0;
    build(d);
    t0 = cyc;
    ts = 0;
    fork
      i_tx.send(fr, nsl);
      while (ts == 0 && cyc < t0 + 4000)
      begin
        @(negedge i_sys_clk);
        if (strobe === 1'b1) ts = cyc - t0;
      end
    join
    take(e);
  endtask

  task automatic s_plain;
    dflt();
    xfer(9'h0a5, ch(9'h0a5, 3'h0));
    check(ts >= (9 * 16 + 9) * TD + 3 && ts <= (9 * 16 + 9) * TD + 10, 1);
  endtask

  task automatic s_nine;
    dflt();
    @(posedge i_sys_clk);
    nine_bit <= 1'b1;
    @(posedge i_sys_clk);
    xfer(9'h15a, ch(9'h15a, 3'h0));
    check(ts >= (10 * 16 + 9) * TD + 3 && ts <= (10 * 16 + 9) * TD + 10, 1);
    @(posedge i_sys_clk);
    nine_bit <= 1'b0;
    @(posedge i_sys_clk);
  endtask

  // every verify triplet; two highs or more must be dropped silently
  task automatic s_verify;
    for (int i = 0; i < 8; i++)
    begin
      dflt();
      vp = i[2:0];
      if ($countones(vp) < 2)
        xfer(9'h033, ch(9'h033, {vp != 3'h0, 2'h0}));
      else
      begin
        build(9'h033);
        fr[255:7] = '1;
        i_tx.send(fr, 48);
        @(negedge i_sys_clk);
        check(full, 0);
        check(busy, 0);
      end
    end
    dflt();
    xfer(9'h0c3, ch(9'h0c3, 3'h0));
  endtask

  task automatic s_data_noise;
    logic [8:0] d;
    for (int i = 0; i < 8; i++)
    begin
      dflt();
      dk = 3;
      dm = i[2:0];
      d = {5'h08, $countones(dm) >= 2, 3'h1};
      xfer(d, ch(d, {dm != 3'h0 && dm != 3'h7, 2'h0}));
    end
  endtask

  task automatic s_start_mid;
    dflt();
    sm = 3'h5;
    xfer(9'h05a, ch(9'h05a, 3'h4));
  endtask

  // every stop triplet, the slot base follows the majority
  task automatic s_stop;
    for (int i = 0; i < 8; i++)
    begin
      dflt();
      pm = i[2:0];
      sb = $countones(pm) >= 2;
      xfer(9'h03c, ch(9'h03c, {pm != 3'h0 && pm != 3'h7, ~sb, 1'b0}));
    end
  endtask

  task automatic s_break;
    dflt();
    pm = 3'h0;
    sb = 1'b0;
    xfer(9'h000, ch(9'h000, 3'h3));
  endtask

  // slow then fast bits; only edge resync keeps the stop samples inside
  task automatic s_resync;
    dflt();
    blen = 17;
    xfer(9'h055, ch(9'h055, 3'h0));
    blen = 15;
    xfer(9'h055, ch(9'h055, 3'h0));
  endtask

  // reader stalls until buffer plus output register plus recovery are full
  task automatic s_fill;
    dflt();
    for (int i = 0; i < 18; i++)
    begin
      build(9'(i * 11));
      i_tx.send(fr, nsl);
    end
    for (int i = 0; i < 18; i++)
      take(ch(9'(i * 11), 3'h0));
    @(negedge i_sys_clk);
    check(full, 0);
  endtask

  // watchdog: the whole run needs about 33000 clocks
  initial
  begin
    repeat (95000) @(posedge i_sys_clk);
    fail_count++;
    complete_run();
  end

  initial
  begin
    repeat (10) @(posedge i_sys_clk);
    i_rst_b <= 1'b1;
    @(negedge i_sys_clk);
    check({full, strobe, busy, rx_char}, 0);
    repeat (20) @(posedge i_sys_clk);
    s_plain();
    s_nine();
    s_verify();
    s_data_noise();
    s_start_mid();
    s_stop();
    s_break();
    s_resync();
    s_fill();
    complete_run();
  end
endmodule
